//--- hw/line_ctrl_port.sv
// transceiver control port, monitor port, LOS merge and reference clocks
`timescale 1ns/1ns
`default_nettype none
module line_ctrl_port
  import line_ctrl_pkg::*;
(
  // clock, reset, enable
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       clkEn,
  // loss of signal, per channel
  input  wire logic [3:0] extLosIn,
  input  wire logic [3:0] extLosEnable,
  input  wire logic [3:0] extLosPolarity,
  input  wire logic [3:0] internalLos,
  output var  logic [3:0] losAlarm,
  // transceiver serial port and monitor
  input  wire logic       portModeStrap,
  input  wire logic       portOutputEnable,
  input  wire logic       monitorClkIn,
  input  wire logic       monitorDataIn,
  input  wire logic       xcvrSerialIn,
  output var  logic [3:0] xcvrSelectN,
  output var  logic       xcvrSerialClk,
  output var  logic       xcvrSerialClkOeN,
  output var  logic       xcvrSerialOut,
  output var  logic       xcvrSerialOutOeN,
  // transfer request from the control side
  input  wire logic       xferStart,
  input  wire logic [1:0] xferChannel,
  input  wire logic [7:0] xferWrData,
  output var  logic       xferBusy,
  output var  logic       xferDone,
  output var  logic [7:0] xferRdData,
  // framer clocks and reference outputs
  input  wire logic [3:0] lineClkIn,
  input  wire logic [3:0] frameSyncIn,
  input  wire logic       refClockAEnable,
  input  wire logic       refClockBEnable,
  input  wire logic       refRateSelect,
  input  wire logic [1:0] refASource,
  input  wire logic [1:0] refBSource,
  output var  logic       refClockAOut,
  output var  logic       refClockAOeN,
  output var  logic       refClockBOut,
  output var  logic       refClockBOeN
);

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [SYNC_BITS-1:0] syncA_reg;
  logic [SYNC_BITS-1:0] syncB_reg;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      syncA_reg <= '0;
      syncB_reg <= '0;
    end
    else if (clkEn)
    begin
      syncA_reg <= {frameSyncIn, lineClkIn, monitorDataIn,
                    monitorClkIn, portModeStrap, xcvrSerialIn,
                    extLosIn};
      syncB_reg <= syncA_reg;
    end
  end

  logic [3:0] losSync;
  logic       sdiSync;
  logic       strapSync;
  logic       monClkSync;
  logic       monDatSync;
  logic [3:0] lineClkSync;
  logic [3:0] fsyncSync;

  assign losSync     = syncB_reg[SY_LOS +: 4];
  assign sdiSync     = syncB_reg[SY_SDI];
  assign strapSync   = syncB_reg[SY_STRAP];
  assign monClkSync  = syncB_reg[SY_MCLK];
  assign monDatSync  = syncB_reg[SY_MDAT];
  assign lineClkSync = syncB_reg[SY_LCLK +: 4];
  assign fsyncSync   = syncB_reg[SY_FSYNC +: 4];

  // ----------------------------------------
  // loss of signal merge
  // ----------------------------------------
  logic [3:0] losAlarm_next;

  always_comb
  begin
    // xor with polarity turns an active-low input into active high
    losAlarm_next = internalLos |
      (extLosEnable & (losSync ^ extLosPolarity));
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      losAlarm <= '0;
    else if (clkEn)
      losAlarm <= losAlarm_next;
  end

  // ----------------------------------------
  // serial port sequencer and pin mux
  // ----------------------------------------
  serial_state_t state_reg, state_next;
  logic [7:0] halfCnt_reg, halfCnt_next;
  logic [2:0] bitCnt_reg, bitCnt_next;
  logic [7:0] txShift_reg, txShift_next;
  logic [7:0] rxShift_reg, rxShift_next;
  logic       sclk_reg, sclk_next;
  logic       sdo_reg, sdo_next;
  logic [3:0] select_next;
  logic       busy_next;
  logic       done_next;
  logic [7:0] rdData_next;
  logic       pinClk_next;
  logic       pinDat_next;
  logic       pinOeN_next;

  always_comb
  begin
    state_next   = state_reg;
    halfCnt_next = halfCnt_reg;
    bitCnt_next  = bitCnt_reg;
    txShift_next = txShift_reg;
    rxShift_next = rxShift_reg;
    sclk_next    = sclk_reg;
    sdo_next     = sdo_reg;
    select_next  = xcvrSelectN;
    busy_next    = xferBusy;
    done_next    = 1'b0;
    rdData_next  = xferRdData;
    if (halfCnt_reg != 8'h00)
      halfCnt_next = halfCnt_reg - 8'h01;
    unique case (state_reg)
      S_IDLE:
      begin
        sclk_next   = SCLK_IDLE;
        select_next = SELECT_IDLE;
        if (xferStart && !strapSync)
        begin
          // only the target line goes low
          select_next[xferChannel] = 1'b0;
          txShift_next = xferWrData;
          bitCnt_next  = 3'h0;
          halfCnt_next = HALF_LAST;
          busy_next    = 1'b1;
          state_next   = S_LEAD;
        end
      end
      S_LEAD:
        if (halfCnt_reg == 8'h00)
        begin
          sclk_next    = 1'b0;
          sdo_next     = txShift_reg[7];
          txShift_next = {txShift_reg[6:0], 1'b0};
          halfCnt_next = HALF_LAST;
          state_next   = S_LOW;
        end
      S_LOW:
        if (halfCnt_reg == 8'h00)
        begin
          sclk_next    = 1'b1;
          rxShift_next = {rxShift_reg[6:0], sdiSync};
          halfCnt_next = HALF_LAST;
          state_next   = S_HIGH;
        end
      S_HIGH:
        if (halfCnt_reg == 8'h00)
        begin
          halfCnt_next = HALF_LAST;
          if (bitCnt_reg == BIT_LAST)
            state_next = S_TAIL;
          else
          begin
            sclk_next    = 1'b0;
            sdo_next     = txShift_reg[7];
            txShift_next = {txShift_reg[6:0], 1'b0};
            bitCnt_next  = bitCnt_reg + 3'h1;
            state_next   = S_LOW;
          end
        end
      S_TAIL:
        if (halfCnt_reg == 8'h00)
        begin
          select_next = SELECT_IDLE;
          busy_next   = 1'b0;
          done_next   = 1'b1;
          rdData_next = rxShift_reg;
          state_next  = S_IDLE;
        end
      default:
        state_next = S_IDLE;
    endcase
    // the strap takes the pins away, so a running transfer is dropped
    if (strapSync && state_reg != S_IDLE)
    begin
      state_next  = S_IDLE;
      select_next = SELECT_IDLE;
      busy_next   = 1'b0;
      sclk_next   = SCLK_IDLE;
    end
    if (strapSync)
    begin
      pinClk_next = monClkSync;
      pinDat_next = monDatSync;
      pinOeN_next = !portOutputEnable;
    end
    else
    begin
      pinClk_next = sclk_next;
      pinDat_next = sdo_next;
      pinOeN_next = 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state_reg        <= S_IDLE;
      halfCnt_reg      <= 8'h00;
      bitCnt_reg       <= 3'h0;
      txShift_reg      <= 8'h00;
      rxShift_reg      <= 8'h00;
      sclk_reg         <= SCLK_IDLE;
      sdo_reg          <= 1'b0;
      xcvrSelectN      <= SELECT_IDLE;
      xferBusy         <= 1'b0;
      xferDone         <= 1'b0;
      xferRdData       <= 8'h00;
      xcvrSerialClk    <= SCLK_IDLE;
      xcvrSerialOut    <= 1'b0;
      xcvrSerialClkOeN <= 1'b0;
      xcvrSerialOutOeN <= 1'b0;
    end
    else if (clkEn)
    begin
      state_reg        <= state_next;
      halfCnt_reg      <= halfCnt_next;
      bitCnt_reg       <= bitCnt_next;
      txShift_reg      <= txShift_next;
      rxShift_reg      <= rxShift_next;
      sclk_reg         <= sclk_next;
      sdo_reg          <= sdo_next;
      xcvrSelectN      <= select_next;
      xferBusy         <= busy_next;
      xferDone         <= done_next;
      xferRdData       <= rdData_next;
      xcvrSerialClk    <= pinClk_next;
      xcvrSerialOut    <= pinDat_next;
      xcvrSerialClkOeN <= pinOeN_next;
      xcvrSerialOutOeN <= pinOeN_next;
    end
  end

  // ----------------------------------------
  // reference clocks
  // ----------------------------------------
  function automatic logic refLevel(
    input logic       enable,
    input logic [1:0] source,
    input logic       fast,
    input logic [3:0] lineClk,
    input logic [3:0] fsync,
    input logic [3:0] los
  );
    // code n picks framer n+1, i.e. index n
    logic clk;
    clk = fast ? lineClk[source] : fsync[source];
    refLevel = enable && !los[source];
    refLevel = refLevel && clk;
  endfunction

  logic refA_next;
  logic refB_next;

  always_comb
  begin
    refA_next = refLevel(refClockAEnable, refASource, refRateSelect,
                         lineClkSync, fsyncSync, losAlarm);
    refB_next = refLevel(refClockBEnable, refBSource, refRateSelect,
                         lineClkSync, fsyncSync, losAlarm);
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      refClockAOut <= 1'b0;
      refClockBOut <= 1'b0;
      refClockAOeN <= 1'b1;
      refClockBOeN <= 1'b1;
    end
    else if (clkEn)
    begin
      refClockAOut <= refA_next;
      refClockBOut <= refB_next;
      refClockAOeN <= !refClockAEnable;
      refClockBOeN <= !refClockBEnable;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  localparam int XFER_MAX = 200;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n || !clkEn);

  sequence xferTaken;
    state_reg == S_IDLE && xferStart && !strapSync;
  endsequence

  sequence xferEnds;
    ##[1:XFER_MAX] xferDone ##1 (xcvrSelectN == SELECT_IDLE);
  endsequence

  chk_los_merge: assert property (
    ##1 losAlarm == $past(internalLos |
        (extLosEnable & (losSync ^ extLosPolarity))))
    else $error("los alarm does not follow its inputs");

  chk_los_low_sense: assert property (
    extLosEnable[0] && extLosPolarity[0] && !losSync[0]
    |=> losAlarm[0])
    else $error("active-low external los ignored");

  chk_select_single: assert property (
    $onehot0(~xcvrSelectN))
    else $error("more than one select asserted");

  // pins still carry monitor data for one cycle after the strap drops, and $changed looks one sample further back
  chk_data_on_fall: assert property (
    !strapSync && !$past(strapSync) && !$past(strapSync, 2) &&
    $changed(xcvrSerialOut)
    |-> $fell(xcvrSerialClk))
    else $error("serial data changed off a falling edge");

  chk_sample_on_rise: assert property (
    state_reg == S_LOW && halfCnt_reg == 8'h00 && !strapSync
    |=> $rose(sclk_reg) &&
        rxShift_reg == {$past(rxShift_reg[6:0]), $past(sdiSync)})
    else $error("return bit not sampled at rising edge");

  chk_monitor_tristate: assert property (
    strapSync && !portOutputEnable
    |=> xcvrSerialClkOeN && xcvrSerialOutOeN)
    else $error("monitor pins driven while disabled");

  chk_ref_disabled: assert property (
    !refClockAEnable && !refClockBEnable
    |=> refClockAOeN && refClockBOeN && !refClockAOut && !refClockBOut)
    else $error("reference clock driven while disabled");

  chk_ref_los_low: assert property (
    losAlarm[refASource] |=> !refClockAOut)
    else $error("reference clock not held low on los");

  // a strap abort legally ends the frame without a done pulse
  chk_xfer_frame: assert property (
    disable iff (!rst_n || !clkEn || strapSync)
    xferTaken |=> xferBusy && !xcvrSelectN[$past(xferChannel)]
    ##0 xferEnds)
    else $error("transfer did not complete and deselect");

endmodule
`default_nettype wire

//--- hw/line_ctrl_pkg.sv
// constants for the line control port and clock reference block
`default_nettype none
package line_ctrl_pkg;
  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int CHANNELS  = 4;
  localparam int DATA_BITS = 8;
  localparam int SYNC_BITS = 16;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int MCLK_PERIOD_NS  = 100;
  localparam int SERIAL_HALF_NS  = 500;
  // least half period, so round up
  localparam int HALF_CYCLES =
    (SERIAL_HALF_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam logic [7:0] HALF_LAST = 8'(HALF_CYCLES - 1);
  localparam logic [2:0] BIT_LAST  = 3'(DATA_BITS - 1);
  // ----------------------------------------
  // positions inside the synchroniser vector
  // ----------------------------------------
  localparam int SY_LOS   = 0;
  localparam int SY_SDI   = 4;
  localparam int SY_STRAP = 5;
  localparam int SY_MCLK  = 6;
  localparam int SY_MDAT  = 7;
  localparam int SY_LCLK  = 8;
  localparam int SY_FSYNC = 12;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [3:0] SELECT_IDLE = 4'hf;
  localparam logic       SCLK_IDLE   = 1'h1;
  // ----------------------------------------
  // serial port sequencer
  // ----------------------------------------
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_LEAD = 3'b001,
    S_LOW  = 3'b010,
    S_HIGH = 3'b011,
    S_TAIL = 3'b100
  } serial_state_t;
endpackage
`default_nettype wire

//--- verif/xcvr_model.sv
// transceiver model on the far side of the serial control port
`timescale 1ns/1ns
`default_nettype none
module xcvr_model (
  // serial port
  input  wire logic [3:0] selN,
  input  wire logic       sclk,
  input  wire logic       sdo,
  output var  logic       sdi,
  // bytes exchanged
  input  wire logic [7:0] retByte,
  output var  logic [7:0] gotByte
);
  logic [7:0] shiftOut;
  logic       lastBit;
  wire        sel = ~&selN;

  initial
  begin
    sdi = 1'h0;
    lastBit = 1'h0;
    shiftOut = 8'h00;
    gotByte = 8'h00;
  end

  always @(posedge sel)
  begin
    shiftOut = retByte;
    gotByte = 8'h00;
  end

  // change on fall so the bit is steady at the rise
  always @(negedge sclk)
    if (sel)
    begin
      sdi = shiftOut[7];
      lastBit = shiftOut[7];
      shiftOut = shiftOut << 1;
    end

  always @(posedge sclk)
    if (sel)
      gotByte = {gotByte[6:0], sdo};

  // released line floats: show the opposite, not the old value
  always @(negedge sel)
    sdi = ~lastBit;
endmodule
`default_nettype wire

//--- verif/line_ctrl_port_bench.sv
// self-checking bench for the line control port
`timescale 1ns/1ns
`default_nettype none
module line_ctrl_port_bench;
  import line_ctrl_pkg::*;
  logic mclk = 0, rst_n = 0, clkEn = 1, lclk = 0;
  logic [3:0] extLosIn = 0, extLosEnable = 0, extLosPolarity = 0;
  logic [3:0] internalLos = 0, losAlarm, xcvrSelectN, clkMask = 0;
  logic [3:0] frameSyncIn = 0;
  logic portModeStrap = 0, portOutputEnable = 0, monData = 0;
  logic xcvrSerialIn, xcvrSerialClk, xcvrSerialClkOeN;
  logic xcvrSerialOut, xcvrSerialOutOeN, xferStart = 0;
  logic xferBusy, xferDone, refA = 0, refB = 0, rate = 0;
  logic [1:0] xferChannel = 0, srcA = 0, srcB = 0;
  logic [7:0] xferWrData = 0, xferRdData, retByte = 0, gotByte;
  logic refClockAOut, refClockAOeN, refClockBOut, refClockBOeN;
  logic monClkSeen;
  int errCount = 0, numChecks = 0, cycles = 0, ca, cb;
  logic [19:0] rows [7] = '{20'hf0000, 20'hff00f, 20'hfff00,
    20'h0ff0f, 20'h53089, 20'hac60c, 20'h00066};

  always #50 mclk = ~mclk;
  initial
  begin
    #137;
    forever #400 lclk = ~lclk;
  end

  line_ctrl_port dut (.mclk(mclk), .rst_n(rst_n), .clkEn(clkEn),
    .extLosIn(extLosIn), .extLosEnable(extLosEnable),
    .extLosPolarity(extLosPolarity), .internalLos(internalLos),
    .losAlarm(losAlarm), .portModeStrap(portModeStrap),
    .portOutputEnable(portOutputEnable), .monitorClkIn(lclk),
    .monitorDataIn(monData), .xcvrSerialIn(xcvrSerialIn),
    .xcvrSelectN(xcvrSelectN), .xcvrSerialClk(xcvrSerialClk),
    .xcvrSerialClkOeN(xcvrSerialClkOeN), .xcvrSerialOut(xcvrSerialOut),
    .xcvrSerialOutOeN(xcvrSerialOutOeN), .xferStart(xferStart),
    .xferChannel(xferChannel), .xferWrData(xferWrData),
    .xferBusy(xferBusy), .xferDone(xferDone), .xferRdData(xferRdData),
    .lineClkIn({4{lclk}} & clkMask), .frameSyncIn(frameSyncIn),
    .refClockAEnable(refA), .refClockBEnable(refB),
    .refRateSelect(rate), .refASource(srcA), .refBSource(srcB),
    .refClockAOut(refClockAOut), .refClockAOeN(refClockAOeN),
    .refClockBOut(refClockBOut), .refClockBOeN(refClockBOeN));

  xcvr_model model (.selN(xcvrSelectN), .sclk(xcvrSerialClk),
    .sdo(xcvrSerialOut), .sdi(xcvrSerialIn), .retByte(retByte),
    .gotByte(gotByte));

  task tally_and_finish;
    $display("checks %0d mismatches %0d", numChecks, errCount);
    if (errCount == 0 && numChecks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task chk(input string nm, input logic [7:0] got, exp);
    numChecks++;
    if (got !== exp)
    begin
      errCount++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task tick(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // frz > 0 holds clkEn low that many cycles right after the start
  task xfer(input logic [1:0] ch, input logic [7:0] wr, rd, input int frz);
    int n;
    n = 0;
    retByte = rd;
    xferChannel = ch;
    xferWrData = wr;
    xferStart = 1;
    tick(1);
    xferStart = 0;
    if (frz > 0)
    begin
      clkEn = 0;
      tick(frz);
      clkEn = 1;
    end
    tick(40);
    chk("select", xcvrSelectN, 4'(~(4'h1 << ch)));
    while (xferDone !== 1'b1 && n < 200)
    begin
      tick(1);
      n++;
    end
    // lead, sixteen clock halves and tail: 18 half periods in all
    chk("latency", 8'(n), 8'(18 * HALF_CYCLES - 40));
    chk("rdData", xferRdData, rd);
    chk("sent", gotByte, wr);
    tick(1);
    chk("idle select", xcvrSelectN, 4'hf);
  endtask

  // edges seen on both reference outputs over a fixed window
  task toggles;
    logic pa, pb;
    pa = refClockAOut;
    pb = refClockBOut;
    ca = 0;
    cb = 0;
    repeat (60)
    begin
      tick(1);
      ca += int'(refClockAOut !== pa);
      cb += int'(refClockBOut !== pb);
      pa = refClockAOut;
      pb = refClockBOut;
    end
  endtask

  // ----------------------------------------
  // hang guard
  // ----------------------------------------
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errCount++;
      tally_and_finish;
    end
  end

  initial
  begin
    tick(12);
    chk("rst select", xcvrSelectN, 4'hf);
    chk("rst refOeN", {refClockAOeN, refClockBOeN}, 2'h3);
    rst_n = 1;
    tick(4);
    chk("clk oe", xcvrSerialClkOeN, 0);
    chk("out oe", xcvrSerialOutOeN, 0);
    foreach (rows[i])
    begin
      {extLosIn, extLosEnable, extLosPolarity, internalLos} = rows[i][19:4];
      tick(5);
      chk("losAlarm", losAlarm, rows[i][3:0]);
    end
    {extLosIn, extLosEnable, internalLos} = 0;
    $display("test los done");
    for (int c = 0; c < 4; c++)
      xfer(2'(c), 8'h96 ^ 8'(c), 8'h3c + 8'(c), (c == 2) ? 20 : 0);
    $display("test transfer done");
    // reset in mid-frame drops the transfer and frees the selects
    retByte = 8'hc3;
    xferChannel = 2'h1;
    xferStart = 1;
    tick(1);
    xferStart = 0;
    tick(20);
    rst_n = 0;
    tick(12);
    chk("mid rst select", xcvrSelectN, 4'hf);
    chk("mid rst busy", xferBusy, 0);
    rst_n = 1;
    tick(3);
    xfer(2'h1, 8'h69, 8'hc3, 0);
    $display("test reset done");
    portModeStrap = 1;
    tick(6);
    chk("mon oe", {xcvrSerialClkOeN, xcvrSerialOutOeN}, 2'h3);
    portOutputEnable = 1;
    monData = 1;
    xferStart = 1;
    tick(6);
    chk("mon start", xferBusy, 0);
    chk("mon data", {xcvrSerialClkOeN, xcvrSerialOut}, 2'h1);
    // link clock flips every 4 cycles, so 16 cycles hold 4 flips
    ca = 0;
    repeat (16)
    begin
      monClkSeen = xcvrSerialClk;
      tick(1);
      ca += int'(xcvrSerialClk !== monClkSeen);
    end
    chk("mon clock", 8'(ca), 8'h04);
    monData = 0;
    xferStart = 0;
    tick(6);
    chk("mon data", xcvrSerialOut, 0);
    portModeStrap = 0;
    tick(4);
    $display("test monitor done");
    {refA, refB, rate} = 3'h7;
    for (int s = 0; s < 4; s++)
    begin
      srcA = 2'(s);
      srcB = 2'(3 - s);
      clkMask = 4'h1 << s;
      // let the old source and alarm drain out of the synchronisers
      tick(4);
      toggles;
      chk("ref a runs", 8'(ca > 4), 1);
      chk("ref b other", 8'(cb), 0);
      internalLos = clkMask;
      tick(2);
      toggles;
      chk("ref a los", refClockAOut, 0);
      chk("ref a los edges", 8'(ca), 0);
      internalLos = 0;
    end
    rate = 0;
    frameSyncIn = 4'h6;
    for (int s = 0; s < 4; s++)
    begin
      srcA = 2'(s);
      srcB = 2'(s);
      tick(5);
      chk("ref 8k", {refClockAOut, refClockBOut}, {2{frameSyncIn[s]}});
    end
    {refA, refB} = 2'h1;
    tick(3);
    chk("ref en", {refClockAOeN, refClockBOeN}, 2'h2);
    $display("test reference done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
